// File: logic/fsg_cfg.svh
/*
  Offsets, field positions and reset values of the frame sync generator.
  Assumes inclusion by bare name from the top module only; the package does not include it.
*/
`ifndef FSG_CFG_SVH
`define FSG_CFG_SVH
// Overview of operation
// - frame pulses run only with run bit and generator sync mode both set
// - receive and transmit framing are chosen separately, any data delay
// - self-triggered transmit emits one sync per holding-to-shift copy
// - copy-triggered framing with delay 1 or 2 may miss top packet rate
// - receive and transmit each accept an external sync on own pin
// - period counter is 12-bit, counts bit clocks from the period setting down to 0
// - width counter is 8-bit and sets how long the pulse stays high
// - generated sync starts low when the generator leaves reset
// - width+1 counted per bit clock, sync low at zero: 1 to 256 clocks
// - period+1 counted alongside, sync high at zero: 1 to 4096 bits
// - with resync on, the period setting is ignored
// - loopback uses transmit sync as receive sync and loops data back
// - no loopback, drive select 0: receive pin input, polarity applied
// - no loopback, drive select 1, no resync: generated sync drives pin and receive
// - resync on, drive select 1: receive pin only resyncs and triggers generated sync
// - loopback, drive select 0: receive pin is left undriven
// - resync: each rising receive sync restarts bit clock, fires a pulse

`define FSG_OFF_CTRL    12'h000
`define FSG_OFF_FRAME   12'h004
`define FSG_OFF_DIV     12'h008
`define FSG_OFF_STATUS  12'h00c

`define FSG_CTRL_W      8
`define FSG_FRAME_PER_LSB 0
`define FSG_FRAME_WID_LSB 16
`define FSG_STAT_PER_LSB  16

`define FSG_CTRL_RST    32'h0000_0000
`define FSG_FRAME_RST   32'h0000_0000
`define FSG_DIV_RST     32'h0000_0000
`endif

// File: logic/fsg_pkg.sv
/*
  Types of the frame sync generator: control fields and pin groups.
  Assumes nothing beyond the cfg header.
*/
`default_nettype none
package fsg_pkg;
  typedef struct packed {
    logic tx_sync_polarity;
    logic tx_sync_drive;
    logic rx_sync_polarity;
    logic rx_sync_drive_select;
    logic loopback_enable;
    logic clock_resync_enable;
    logic tx_sync_from_generator;
    logic frame_gen_run;
  } fsg_ctrl_t;

  typedef struct packed {
    logic ext_bit_clk;
    logic rx_sync_pin;
    logic tx_sync_pin;
    logic rx_serial_in;
  } fsg_pins_t;
endpackage : fsg_pkg
`default_nettype wire

// File: logic/fsg_sync2.sv
/*
  Two-flop synchroniser for a group of asynchronous levels.
  Assumes inputs are levels slow against the clock.
*/
`default_nettype none
module fsg_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  if (W < 1) begin : g_chk
    $error("fsg_sync2: W must be at least 1");
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_d;
      sync_ff <= meta_ff;
    end
  end

  assign o_q = sync_ff;
endmodule : fsg_sync2
`default_nettype wire

// File: logic/fsg_down_cnt.sv
/*
  Loadable down-counter that holds at zero; clear beats load beats count.
  Assumes all controls come from the same clock.
*/
`default_nettype none
module fsg_down_cnt #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic         i_clr,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_val,
  input  wire logic         i_dec,
  output logic      [W-1:0] o_count,
  output logic              o_zero
);
  logic [W-1:0] cnt_ff;

  if (W < 1) begin : g_chk
    $error("fsg_down_cnt: W must be at least 1");
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_ff <= '0;
    end else if (i_clr) begin
      cnt_ff <= '0;
    end else if (i_load) begin
      cnt_ff <= i_val;
    end else if (i_dec && (cnt_ff != '0)) begin
      cnt_ff <= cnt_ff - W'(1);
    end
  end

  assign o_count = cnt_ff;
  assign o_zero  = (cnt_ff == '0);
endmodule : fsg_down_cnt
`default_nettype wire

// File: logic/fsg_frame_sync_gen.sv
/*
  Frame sync generator with receive sync selection and APB registers.
  Assumes an APB master on i_core_clk; pins and the external bit clock
  are asynchronous and are synchronised here; i_tx_copy and
  i_tx_serial_out come from logic on i_core_clk.
*/
`include "fsg_cfg.svh"
`default_nettype none
module fsg_frame_sync_gen #(
  parameter int ADDR_W = 12,
  parameter int PER_W  = 12,
  parameter int WID_W  = 8,
  parameter int DIV_W  = 8
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_arst_n,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic              i_ext_bit_clk,
  input  wire logic              i_rx_sync_pin,
  output logic                   o_rx_sync_pin,
  output logic                   o_rx_sync_pin_oe_n,
  input  wire logic              i_tx_sync_pin,
  output logic                   o_tx_sync_pin,
  output logic                   o_tx_sync_pin_oe_n,
  input  wire logic              i_rx_serial_in,
  input  wire logic              i_tx_serial_out,
  input  wire logic              i_tx_copy,
  output logic                   o_rx_serial_data,
  output logic                   o_rx_sync_internal,
  output logic                   o_tx_sync_internal,
  output logic                   o_gen_frame_sync,
  output logic                   o_gen_bit_clock
);

  if (ADDR_W < 4 || ADDR_W > 32) begin : g_chk_addr
    $error("fsg_frame_sync_gen: ADDR_W out of range");
  end
  if (PER_W < 1 || PER_W > 12) begin : g_chk_per
    $error("fsg_frame_sync_gen: PER_W must be 1 to 12");
  end
  if (WID_W < 1 || WID_W > 8) begin : g_chk_wid
    $error("fsg_frame_sync_gen: WID_W must be 1 to 8");
  end
  if (DIV_W < 1 || DIV_W > 8) begin : g_chk_div
    $error("fsg_frame_sync_gen: DIV_W must be 1 to 8");
  end

  localparam logic [ADDR_W-1:0] A_CTRL   = ADDR_W'(`FSG_OFF_CTRL);
  localparam logic [ADDR_W-1:0] A_FRAME  = ADDR_W'(`FSG_OFF_FRAME);
  localparam logic [ADDR_W-1:0] A_DIV    = ADDR_W'(`FSG_OFF_DIV);
  localparam logic [ADDR_W-1:0] A_STATUS = ADDR_W'(`FSG_OFF_STATUS);

  // register file state
  logic [31:0]              ctrl_ff;
  logic [31:0]              frame_ff;
  logic [31:0]              div_ff;
  logic [31:0]              prdata_ff;
  logic                     pready_ff;
  logic                     pslverr_ff;
  fsg_pkg::fsg_ctrl_t       ctrl;

  // synchronised pins and edge history
  fsg_pkg::fsg_pins_t       pins_raw;
  fsg_pkg::fsg_pins_t       pins;
  logic                     ext_clk_d_ff;
  logic                     rx_act_d_ff;

  // bit clock and generator
  logic [DIV_W-1:0]         div_cnt;
  logic                     div_zero;
  logic [PER_W-1:0]         per_cnt;
  logic                     per_zero;
  logic [WID_W-1:0]         wid_cnt;
  logic                     wid_zero;
  logic                     fsg_ff;
  logic                     bit_tick_ff;
  logic                     copy_fs_ff;

  // registered outputs
  logic                     rx_int_ff;
  logic                     tx_int_ff;
  logic                     rx_data_ff;
  logic                     rx_pin_ff;
  logic                     rx_pin_oe_n_ff;
  logic                     tx_pin_ff;
  logic                     tx_pin_oe_n_ff;

  // combinational terms
  logic                     setup;
  logic                     wr_en;
  logic                     addr_hit;
  logic                     ext_rise;
  logic                     rx_act;
  logic                     resync_evt;
  logic                     bit_tick;
  logic                     gen_en;
  logic                     frame_start;
  logic                     nxt_tx_int;
  logic                     nxt_rx_int;
  logic                     nxt_rx_pin;
  logic                     nxt_rx_pin_oe_n;
  logic                     nxt_tx_pin;
  logic                     nxt_tx_pin_oe_n;
  logic [31:0]              nxt_prdata;
  logic [31:0]              status;

  function automatic logic [31:0] merge_strb(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  assign ctrl = fsg_pkg::fsg_ctrl_t'(ctrl_ff[`FSG_CTRL_W-1:0]);

  // apb decode
  assign setup    = i_psel && !i_penable;
  assign wr_en    = i_psel && i_penable && pready_ff && i_pwrite;
  assign addr_hit = (i_paddr == A_CTRL) || (i_paddr == A_FRAME)
                 || (i_paddr == A_DIV)  || (i_paddr == A_STATUS);

  // answer is prepared in the setup cycle, ready in the access cycle
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup && !addr_hit;
    end
  end

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (!i_pwrite) begin
      if (i_paddr == A_CTRL) begin
        nxt_prdata = ctrl_ff;
      end else if (i_paddr == A_FRAME) begin
        nxt_prdata = frame_ff;
      end else if (i_paddr == A_DIV) begin
        nxt_prdata = div_ff;
      end else if (i_paddr == A_STATUS) begin
        nxt_prdata = status;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (setup) begin
      prdata_ff <= nxt_prdata;
    end
  end

  // software-written configuration steering the generator
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_ff  <= `FSG_CTRL_RST;
      frame_ff <= `FSG_FRAME_RST;
      div_ff   <= `FSG_DIV_RST;
    end else if (wr_en) begin
      if (i_paddr == A_CTRL) begin
        ctrl_ff <= merge_strb(ctrl_ff, i_pwdata, i_pstrb)
                 & 32'h0000_00ff;
      end
      if (i_paddr == A_FRAME) begin
        frame_ff <= merge_strb(frame_ff, i_pwdata, i_pstrb)
                  & 32'h00ff_0fff;
      end
      if (i_paddr == A_DIV) begin
        div_ff <= merge_strb(div_ff, i_pwdata, i_pstrb)
                & 32'h0000_00ff;
      end
    end
  end

  always_comb begin
    status = 32'h0000_0000;
    status[0] = fsg_ff;
    status[1] = rx_int_ff;
    status[2] = tx_int_ff;
    status[3] = copy_fs_ff;
    status[`FSG_STAT_PER_LSB +: PER_W] = per_cnt;
  end

  // pin synchronisers
  assign pins_raw.ext_bit_clk  = i_ext_bit_clk;
  assign pins_raw.rx_sync_pin  = i_rx_sync_pin;
  assign pins_raw.tx_sync_pin  = i_tx_sync_pin;
  assign pins_raw.rx_serial_in = i_rx_serial_in;

  fsg_sync2 #(
    .W (4)
  ) u_pin_sync (
    .i_clk    (i_core_clk),
    .i_arst_n (i_arst_n),
    .i_d      (pins_raw),
    .o_q      (pins)
  );

  assign rx_act = pins.rx_sync_pin ^ ctrl.rx_sync_polarity;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ext_clk_d_ff <= 1'b0;
      rx_act_d_ff  <= 1'b0;
    end else begin
      ext_clk_d_ff <= pins.ext_bit_clk;
      rx_act_d_ff  <= rx_act;
    end
  end

  assign ext_rise   = pins.ext_bit_clk && !ext_clk_d_ff;
  assign resync_evt = ctrl.clock_resync_enable
                   && rx_act && !rx_act_d_ff;

  // bit clock divider, restarted by resync
  fsg_down_cnt #(
    .W (DIV_W)
  ) u_div_cnt (
    .i_clk    (i_core_clk),
    .i_arst_n (i_arst_n),
    .i_clr    (1'b0),
    .i_load   (resync_evt || (ext_rise && div_zero)),
    .i_val    (div_ff[DIV_W-1:0]),
    .i_dec    (ext_rise),
    .o_count  (div_cnt),
    .o_zero   (div_zero)
  );

  assign bit_tick = resync_evt || (ext_rise && div_zero);

  // generator enable and frame start
  assign gen_en = ctrl.frame_gen_run
               && ctrl.tx_sync_from_generator;
  assign frame_start = gen_en
    && (ctrl.clock_resync_enable ? resync_evt
                                 : (bit_tick && per_zero));

  fsg_down_cnt #(
    .W (PER_W)
  ) u_per_cnt (
    .i_clk    (i_core_clk),
    .i_arst_n (i_arst_n),
    .i_clr    (!gen_en || ctrl.clock_resync_enable),
    .i_load   (frame_start),
    .i_val    (frame_ff[`FSG_FRAME_PER_LSB +: PER_W]),
    .i_dec    (bit_tick),
    .o_count  (per_cnt),
    .o_zero   (per_zero)
  );

  fsg_down_cnt #(
    .W (WID_W)
  ) u_wid_cnt (
    .i_clk    (i_core_clk),
    .i_arst_n (i_arst_n),
    .i_clr    (!gen_en),
    .i_load   (frame_start),
    .i_val    (frame_ff[`FSG_FRAME_WID_LSB +: WID_W]),
    .i_dec    (bit_tick),
    .o_count  (wid_cnt),
    .o_zero   (wid_zero)
  );

  // generated frame sync level
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fsg_ff <= 1'b0;
    end else if (!gen_en) begin
      fsg_ff <= 1'b0;
    end else if (frame_start) begin
      fsg_ff <= 1'b1;
    end else if (bit_tick && wid_zero) begin
      fsg_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bit_tick_ff <= 1'b0;
    end else begin
      bit_tick_ff <= bit_tick;
    end
  end

  // copy-triggered sync, high until the next bit tick; a new copy wins the clear
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      copy_fs_ff <= 1'b0;
    end else if (i_tx_copy) begin
      copy_fs_ff <= 1'b1;
    end else if (bit_tick) begin
      copy_fs_ff <= 1'b0;
    end
  end

  // transmit sync source
  always_comb begin
    if (ctrl.tx_sync_from_generator) begin
      nxt_tx_int = fsg_ff;
    end else if (ctrl.tx_sync_drive) begin
      nxt_tx_int = copy_fs_ff;
    end else begin
      nxt_tx_int = pins.tx_sync_pin ^ ctrl.tx_sync_polarity;
    end
    nxt_tx_pin      = nxt_tx_int ^ ctrl.tx_sync_polarity;
    nxt_tx_pin_oe_n = !ctrl.tx_sync_drive;
  end

  // receive sync source and pin direction
  always_comb begin
    if (ctrl.loopback_enable) begin
      nxt_rx_int = nxt_tx_int;
    end else if (!ctrl.rx_sync_drive_select) begin
      nxt_rx_int = rx_act;
    end else begin
      nxt_rx_int = fsg_ff;
    end
    nxt_rx_pin = nxt_rx_int ^ ctrl.rx_sync_polarity;
    nxt_rx_pin_oe_n = !(ctrl.rx_sync_drive_select
                        && !ctrl.clock_resync_enable);
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_int_ff      <= 1'b0;
      tx_int_ff      <= 1'b0;
      rx_pin_ff      <= 1'b0;
      rx_pin_oe_n_ff <= 1'b1;
      tx_pin_ff      <= 1'b0;
      tx_pin_oe_n_ff <= 1'b1;
    end else begin
      rx_int_ff      <= nxt_rx_int;
      tx_int_ff      <= nxt_tx_int;
      rx_pin_ff      <= nxt_rx_pin;
      rx_pin_oe_n_ff <= nxt_rx_pin_oe_n;
      tx_pin_ff      <= nxt_tx_pin;
      tx_pin_oe_n_ff <= nxt_tx_pin_oe_n;
    end
  end

  // receive data, looped back from transmit when asked
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_data_ff <= 1'b0;
    end else if (ctrl.loopback_enable) begin
      rx_data_ff <= i_tx_serial_out;
    end else begin
      rx_data_ff <= pins.rx_serial_in;
    end
  end

  assign o_prdata           = prdata_ff;
  assign o_pready           = pready_ff;
  assign o_pslverr          = pslverr_ff;
  assign o_rx_sync_pin      = rx_pin_ff;
  assign o_rx_sync_pin_oe_n = rx_pin_oe_n_ff;
  assign o_tx_sync_pin      = tx_pin_ff;
  assign o_tx_sync_pin_oe_n = tx_pin_oe_n_ff;
  assign o_rx_serial_data   = rx_data_ff;
  assign o_rx_sync_internal = rx_int_ff;
  assign o_tx_sync_internal = tx_int_ff;
  assign o_gen_frame_sync   = fsg_ff;
  assign o_gen_bit_clock    = bit_tick_ff;

endmodule : fsg_frame_sync_gen
`default_nettype wire

// File: testbench/fsg_frame_sync_gen_monitor.sv
/* port checker of the frame sync generator.
   assumes a bind onto fsg_frame_sync_gen, one clock domain. */
`default_nettype none
module fsg_mon #(
  parameter int ADDR_W = 12
) (
  input wire logic              i_core_clk,
  input wire logic              i_arst_n,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0]       i_pwdata,
  input wire logic [3:0]        i_pstrb,
  input wire logic              o_pready,
  input wire logic              o_pslverr,
  input wire logic              i_tx_serial_out,
  input wire logic              i_tx_copy,
  input wire logic              o_rx_serial_data,
  input wire logic              o_rx_sync_pin,
  input wire logic              o_rx_sync_pin_oe_n,
  input wire logic              o_rx_sync_internal,
  input wire logic              o_tx_sync_internal,
  input wire logic              o_gen_frame_sync,
  input wire logic              o_gen_bit_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ctrl_ff;
  logic [7:0] ctrl_q_ff;
  logic       ok;
  logic       settled;

  // shadow of the control word
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_ff <= 8'h00;
    end else if (i_psel && i_penable && o_pready && i_pwrite &&
                 i_paddr == '0 && i_pstrb[0]) begin
      ctrl_ff <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_q_ff <= 8'h00;
    end else begin
      ctrl_q_ff <= ctrl_ff;
    end
  end

  assign ok      = ctrl_ff[0] & ctrl_ff[1];
  assign settled = (ctrl_ff == ctrl_q_ff);

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_copy;
    i_tx_copy && settled && ctrl_ff[6] && !ctrl_ff[1];
  endsequence

  property p_apb_rdy;
    s_setup |=> o_pready;
  endproperty
  property p_apb_err;
    s_setup ##0 i_paddr > 12'h00c |=> o_pslverr && o_pready;
  endproperty
  property p_gate;
    !ok [*3] |-> !o_gen_frame_sync;
  endproperty
  property p_rise;
    $rose(o_gen_frame_sync) |-> ##[0:1] o_gen_bit_clock;
  endproperty
  property p_fall;
    ok [*3] ##0 $fell(o_gen_frame_sync) |-> ##[0:1] o_gen_bit_clock;
  endproperty
  property p_lpbk;
    ctrl_ff[3] && settled |-> o_rx_sync_internal == o_tx_sync_internal;
  endproperty
  property p_lpdat;
    ctrl_ff[3] && settled |-> o_rx_serial_data == $past(i_tx_serial_out);
  endproperty
  property p_oe;
    settled |-> o_rx_sync_pin_oe_n == !(ctrl_ff[4] && !ctrl_ff[2]);
  endproperty
  property p_drv;
    settled && ctrl_ff[4] && !ctrl_ff[2] && !ctrl_ff[3] |->
      o_rx_sync_internal == $past(o_gen_frame_sync) &&
      o_rx_sync_pin == ($past(o_gen_frame_sync) ^ ctrl_ff[5]);
  endproperty
  property p_copy;
    s_copy |-> ##[1:2] o_tx_sync_internal;
  endproperty

  a_apb_rdy: assert property (p_apb_rdy)
    else $error("no ready after setup");
  a_apb_err: assert property (p_apb_err)
    else $error("unmapped access without error");
  a_gate: assert property (p_gate)
    else $error("frame sync high while generator off");
  a_rise: assert property (p_rise)
    else $error("frame start without bit tick");
  a_fall: assert property (p_fall)
    else $error("frame end without bit tick");
  a_lpbk: assert property (p_lpbk)
    else $error("loopback receive sync differs");
  a_lpdat: assert property (p_lpdat)
    else $error("loopback data differs");
  a_oe: assert property (p_oe)
    else $error("receive sync pin enable wrong");
  a_drv: assert property (p_drv)
    else $error("generated sync not on receive side");
  a_copy: assert property (p_copy)
    else $error("no sync after copy");
endmodule : fsg_mon

bind fsg_frame_sync_gen fsg_mon #(.ADDR_W(ADDR_W)) u_mon (
  .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_tx_serial_out(i_tx_serial_out),
  .i_tx_copy(i_tx_copy), .o_rx_serial_data(o_rx_serial_data),
  .o_rx_sync_pin(o_rx_sync_pin), .o_rx_sync_pin_oe_n(o_rx_sync_pin_oe_n),
  .o_rx_sync_internal(o_rx_sync_internal),
  .o_tx_sync_internal(o_tx_sync_internal),
  .o_gen_frame_sync(o_gen_frame_sync), .o_gen_bit_clock(o_gen_bit_clock));
`default_nettype wire

// File: testbench/fsg_partner.sv
/* far serial device: free bit clock, sync pins, receive data.
   assumes the block's pin drive values and enables. */
`default_nettype none
module fsg_partner (
  input  wire logic i_rx_drv,
  input  wire logic i_tx_drv,
  input  wire logic i_rx_out,
  input  wire logic i_rx_oe_n,
  input  wire logic i_tx_out,
  input  wire logic i_tx_oe_n,
  output logic      o_bit_clk,
  output logic      o_rx_pin,
  output logic      o_tx_pin,
  output logic      o_rx_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_bit_clk = 1'b0;
    #137;
    forever #400 o_bit_clk = ~o_bit_clk;
  end
  initial o_rx_data = 1'b0;
  always @(posedge o_bit_clk) o_rx_data <= ~o_rx_data;
  // pin level from whichever side drives it
  assign o_rx_pin = i_rx_oe_n ? i_rx_drv : i_rx_out;
  assign o_tx_pin = i_tx_oe_n ? i_tx_drv : i_tx_out;
endmodule : fsg_partner
`default_nettype wire

// File: testbench/fsg_frame_sync_gen_tb.sv
/* self-checking bench of the frame sync generator.
   assumes the partner model and the bound port checker. */
`default_nettype none
module fsg_frame_sync_gen_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        bclk, rx_pin, rxo, rxoe, tx_pin, txo, txoe, rxd, txsd;
  logic        copy, rxdata, rxint, txint, fsg, gbc, rx_drv, tx_drv, pv;
  int          err_total, checks_done, i, k, w, p, hi, per, r;
  int          m [5];
  logic [31:0] msk [3] = '{32'h0000_00ff, 32'h00ff_0fff, 32'h0000_00ff};

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  fsg_frame_sync_gen dut (
    .i_core_clk(clk), .i_arst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(4'hf), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_ext_bit_clk(bclk),
    .i_rx_sync_pin(rx_pin), .o_rx_sync_pin(rxo),
    .o_rx_sync_pin_oe_n(rxoe), .i_tx_sync_pin(tx_pin),
    .o_tx_sync_pin(txo), .o_tx_sync_pin_oe_n(txoe),
    .i_rx_serial_in(rxd), .i_tx_serial_out(txsd), .i_tx_copy(copy),
    .o_rx_serial_data(rxdata), .o_rx_sync_internal(rxint),
    .o_tx_sync_internal(txint), .o_gen_frame_sync(fsg),
    .o_gen_bit_clock(gbc));

  fsg_partner u_far (.i_rx_drv(rx_drv), .i_tx_drv(tx_drv), .i_rx_out(rxo),
    .i_rx_oe_n(rxoe), .i_tx_out(txo), .i_tx_oe_n(txoe), .o_bit_clk(bclk),
    .o_rx_pin(rx_pin), .o_tx_pin(tx_pin), .o_rx_data(rxd));

  task automatic chk(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      $display("[ERR] %s expected %h seen %h", n, x, g);
      err_total++;
    end
  endtask : chk

  task automatic chk_cnt(input string n, input int x, input int g);
    checks_done++;
    if (g != x) begin
      $display("[ERR] %s expected %0d seen %0d", n, x, g);
      err_total++;
    end
  endtask : chk_cnt

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  task automatic hang();
    $display("[ERR] wait expected done seen timeout");
    err_total++;
    end_of_test();
  endtask : hang

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) hang();
  endtask : apb

  task automatic wr(input int a, input logic [31:0] d);
    apb(1'b1, 12'(a * 4), d);
    if (a < 3) m[a] = d & msk[a];
  endtask : wr

  task automatic rd(input int a);
    apb(1'b0, 12'(a * 4), 32'h0000_0000);
    chk("rdata", m[a], q);
    chk("pslverr", a > 3, e);
  endtask : rd

  // counts rising edges of generated (sel 0) or transmit (sel 1) sync
  task automatic rises(input int n, input int sel);
    logic s;
    repeat (n) begin
      @(negedge clk);
      s = sel ? txint : fsg;
      if (pv === 1'b0 && s === 1'b1) r++;
      pv = s;
    end
  endtask : rises

  task automatic frame();
    int n, ph;
    ph = 0;
    hi = 0;
    per = 0;
    pv = 1'b1;
    for (n = 0; n < 20000 && ph < 2; n++) begin
      @(negedge clk);
      if (pv === 1'b0 && fsg === 1'b1) ph++;
      if (ph == 1 && gbc === 1'b1) per++;
      if (ph == 1 && gbc === 1'b1 && fsg === 1'b1) hi++;
      pv = fsg;
    end
    if (ph < 2) hang();
  endtask : frame

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {rx_drv, tx_drv, txsd, copy} = '0;
    rst_n = 1'b0;
    err_total = 0;
    checks_done = 0;
    m = '{default: 0};
    void'($urandom(32'h454e1c2e));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("gen_sync", 1'b0, fsg);
    chk("rx_oe_n", 1'b1, rxoe);
    for (i = 0; i < 5; i++) rd(i);
    $display("test reset done");
    wr(1, $urandom);
    wr(2, $urandom);
    wr(3, 32'hffff_ffff);
    for (i = 0; i < 4; i++) rd(i);
    $display("test registers done");
    wr(2, 0);
    wr(1, 32'h0000_0003);
    for (k = 1; k < 3; k++) begin
      wr(0, k);
      rd(0);
      r = 0;
      rises(200, 0);
      chk_cnt("gated_pulses", 0, r);
    end
    $display("test gating done");
    for (k = 0; k < 4; k++) begin
      w = (k == 0) ? 0 : (k == 1) ? 255 : $urandom_range(6);
      p = (k == 0) ? 3 : (k == 1) ? 299 : w + 1 + $urandom_range(30);
      wr(2, k % 2);
      wr(1, (w << 16) | p);
      wr(0, 3 | (k << 4));
      frame();
      chk_cnt("width_ticks", w + 1, hi);
      chk_cnt("period_ticks", p + 1, per);
      wr(0, 0);
    end
    $display("test frames done");
    wr(1, 32'h0000_0003);
    wr(0, 32'h0000_0007);
    rises(300, 0);
    r = 0;
    for (k = 0; k < 4; k++) begin
      rx_drv <= 1'b1;
      rises(40, 0);
      rx_drv <= 1'b0;
      rises(300, 0);
    end
    chk_cnt("resync_pulses", 4, r);
    chk("rx_oe_n", 1'b1, rxoe);
    $display("test resync done");
    for (k = 0; k < 4; k++) begin
      wr(0, k[1] ? 32'h0000_00a0 : 32'h0000_0000);
      rx_drv <= k[0];
      tx_drv <= k[0];
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk("rx_sync_int", k[0] ^ k[1], rxint);
      chk("tx_sync_int", k[0] ^ k[1], txint);
      chk("tx_oe_n", 1'b1, txoe);
      @(posedge clk);
      pv = rxd;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("rx_data", pv, rxdata);
    end
    $display("test external syncs done");
    wr(0, 32'h0000_0008);
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      txsd <= 1'($urandom);
      @(posedge clk);
      @(negedge clk);
      chk("rx_data", txsd, rxdata);
      chk("rx_oe_n", 1'b1, rxoe);
    end
    $display("test loopback done");
    wr(0, 32'h0000_00c0);
    pv = 1'b1;
    r = 0;
    for (k = 0; k < 3; k++) begin
      @(posedge clk);
      copy <= 1'b1;
      @(posedge clk);
      copy <= 1'b0;
      rises(30, 1);
    end
    chk_cnt("copy_syncs", 3, r);
    chk("tx_oe_n", 1'b0, txoe);
    chk("tx_pin", !txint, txo);
    $display("test copy sync done");
    end_of_test();
  end
endmodule : fsg_frame_sync_gen_tb
`default_nettype wire
